// file: hdl/meter_event_pkg.sv
// Package with register map, field layout and carrier types of the flags.
package meter_event_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 19;
  localparam int SIGN_W = 9;
  localparam int PHASES = 3;

  // Register addresses on the serial register port.
  localparam logic [15:0] ADDR_STATUS = 16'hE502;
  localparam logic [15:0] ADDR_MEAS_MODE = 16'hE700;
  localparam logic [15:0] ADDR_PULSE_MODE = 16'hE610;
  localparam logic [15:0] ADDR_POWER_SIGN = 16'hE617;

  // Status field positions.
  localparam int ST_TOTAL_ACTIVE_HALF = 0;
  localparam int ST_FUND_ACTIVE_HALF = 1;
  localparam int ST_TOTAL_REACTIVE_HALF = 2;
  localparam int ST_FUND_REACTIVE_HALF = 3;
  localparam int ST_APPARENT_HALF = 4;
  localparam int ST_LINE_CYCLE_DONE = 5;
  localparam int ST_ACTIVE_SIGN_BASE = 6;
  localparam int ST_SUM_ONE_SIGN = 9;
  localparam int ST_REACTIVE_SIGN_BASE = 10;
  localparam int ST_SUM_TWO_SIGN = 13;
  localparam int ST_PULSE_BASE = 14;
  localparam int ST_DSP_PASS_DONE = 17;
  localparam int ST_SUM_THREE_SIGN = 18;

  // Power sign register field positions.
  localparam int SG_ACTIVE_BASE = 0;
  localparam int SG_SUM_ONE = 3;
  localparam int SG_REACTIVE_BASE = 4;
  localparam int SG_SUM_TWO = 7;
  localparam int SG_SUM_THREE = 8;

  // Measurement mode and pulse mode fields.
  localparam int MM_ACTIVE_SEL = 0;
  localparam int MM_REACTIVE_SEL = 1;
  localparam int MM_W = 2;
  localparam int PM_SEL_W = 3;
  localparam int PM_DIS_BASE = 9;
  localparam int PM_W = 12;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [11:0] PULSE_MODE_RESET = 12'h000;

  // Energy accumulator bit 30 values, one bit per phase and kind.
  typedef struct packed {
    logic [PHASES-1:0] total_active;
    logic [PHASES-1:0] fund_active;
    logic [PHASES-1:0] total_reactive;
    logic [PHASES-1:0] fund_reactive;
    logic [PHASES-1:0] apparent;
  } energy_bit30_t;

  // Signs of the power quantities, 1 means negative.
  typedef struct packed {
    logic [PHASES-1:0] total_active;
    logic [PHASES-1:0] fund_active;
    logic [PHASES-1:0] total_reactive;
    logic [PHASES-1:0] fund_reactive;
    logic [PHASES-1:0] sum;
  } power_sign_in_t;

  // Serial register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // Whole state of the flag block.
  typedef struct packed {
    logic [FLAG_W-1:0] status;
    logic [SIGN_W-1:0] sign;
    logic [MM_W-1:0] meas_mode;
    logic [PM_W-1:0] pulse_mode;
    logic [DATA_W-1:0] rdata;
    logic [5*PHASES-1:0] bit30_prev;
    logic [PHASES-1:0] pulse_prev;
    logic primed;
  } flags_state_t;

endpackage

// file: hdl/metering_event_status_flags.sv
// Event status flags of the polyphase metering engine.
// Functional notes
// - Total active bit 30 change sets bit 0
// - Fundamental active bit 30 change sets bit 1
// - Total reactive bit 30 change sets bit 2
// - Fundamental reactive bit 30 change sets bit 3
// - Apparent energy bit 30 change sets bit 4
// - Line cycle integration end sets bit 5
// - Active sign change sets bits 6 to 8
// - Reactive sign change sets bits 10 to 12
// - Summed power sign change sets 9, 13, 18
// - New signs shown in power sign register
// - Pulse output falling edge sets bits 14-16
// - Pulse flags set even when output disabled
// - Pulse mode fields select pulse power quantities
// - DSP pass completion sets bit 17
// - Status bits 31 to 19 read zero
`timescale 1ns/1ps
module metering_event_status_flags #(
  parameter int PHASES = meter_event_pkg::PHASES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Serial register port
  input wire meter_event_pkg::reg_req_t reg_req_i,
  output logic [meter_event_pkg::DATA_W-1:0] reg_rdata_o,
  // Measurement engine events
  input wire meter_event_pkg::energy_bit30_t energy_bit30_i,
  input wire meter_event_pkg::power_sign_in_t power_sign_i,
  input wire logic line_cycle_done_i,
  input wire logic dsp_pass_done_i,
  input wire logic [PHASES-1:0] pulse_output_i,
  // Status and configuration
  output logic [meter_event_pkg::FLAG_W-1:0] event_status_o,
  output logic [meter_event_pkg::SIGN_W-1:0] power_sign_o,
  output logic [meter_event_pkg::MM_W-1:0] meas_mode_o,
  output logic [PHASES*meter_event_pkg::PM_SEL_W-1:0] pulse_power_select_o,
  output logic [PHASES-1:0] pulse_disable_o
);

  meter_event_pkg::flags_state_t s_q;
  meter_event_pkg::flags_state_t s_d;

  meter_event_pkg::energy_bit30_t bit30_prev;
  logic [PHASES-1:0] act_sel;
  logic [PHASES-1:0] react_sel;
  logic [meter_event_pkg::SIGN_W-1:0] sign_new;
  logic [meter_event_pkg::FLAG_W-1:0] set_ev;
  logic [meter_event_pkg::FLAG_W-1:0] clr_ev;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  function automatic logic flip(input logic [PHASES-1:0] now,
                                input logic [PHASES-1:0] prev);
    flip = |(now ^ prev);
  endfunction

  // The previous accumulator sample is kept flat in the state word.
  assign bit30_prev = s_q.bit30_prev;

  always_comb begin
    s_d = s_q;
    // Sign source chosen per mode bit.
    act_sel = s_q.meas_mode[meter_event_pkg::MM_ACTIVE_SEL] ?
      power_sign_i.fund_active : power_sign_i.total_active;
    react_sel = s_q.meas_mode[meter_event_pkg::MM_REACTIVE_SEL] ?
      power_sign_i.fund_reactive : power_sign_i.total_reactive;
    sign_new = {power_sign_i.sum[2], power_sign_i.sum[1], react_sel,
                power_sign_i.sum[0], act_sel};
    set_ev = '0;
    // Accumulator edges count only once the previous copy is valid.
    if (s_q.primed) begin
      set_ev[meter_event_pkg::ST_TOTAL_ACTIVE_HALF] =
        flip(energy_bit30_i.total_active, bit30_prev.total_active);
      set_ev[meter_event_pkg::ST_FUND_ACTIVE_HALF] =
        flip(energy_bit30_i.fund_active, bit30_prev.fund_active);
      set_ev[meter_event_pkg::ST_TOTAL_REACTIVE_HALF] =
        flip(energy_bit30_i.total_reactive,
             bit30_prev.total_reactive);
      set_ev[meter_event_pkg::ST_FUND_REACTIVE_HALF] =
        flip(energy_bit30_i.fund_reactive, bit30_prev.fund_reactive);
      set_ev[meter_event_pkg::ST_APPARENT_HALF] =
        flip(energy_bit30_i.apparent, bit30_prev.apparent);
    end
    set_ev[meter_event_pkg::ST_LINE_CYCLE_DONE] = line_cycle_done_i;
    set_ev[meter_event_pkg::ST_DSP_PASS_DONE] = dsp_pass_done_i;
    for (int i = 0; i < PHASES; i++) begin
      set_ev[meter_event_pkg::ST_ACTIVE_SIGN_BASE + i] =
        sign_new[meter_event_pkg::SG_ACTIVE_BASE + i] ^
        s_q.sign[meter_event_pkg::SG_ACTIVE_BASE + i];
      set_ev[meter_event_pkg::ST_REACTIVE_SIGN_BASE + i] =
        sign_new[meter_event_pkg::SG_REACTIVE_BASE + i] ^
        s_q.sign[meter_event_pkg::SG_REACTIVE_BASE + i];
      // Disable bits are deliberately not consulted here.
      set_ev[meter_event_pkg::ST_PULSE_BASE + i] =
        s_q.pulse_prev[i] & ~pulse_output_i[i];
    end
    set_ev[meter_event_pkg::ST_SUM_ONE_SIGN] =
      sign_new[meter_event_pkg::SG_SUM_ONE] ^
      s_q.sign[meter_event_pkg::SG_SUM_ONE];
    set_ev[meter_event_pkg::ST_SUM_TWO_SIGN] =
      sign_new[meter_event_pkg::SG_SUM_TWO] ^
      s_q.sign[meter_event_pkg::SG_SUM_TWO];
    set_ev[meter_event_pkg::ST_SUM_THREE_SIGN] =
      sign_new[meter_event_pkg::SG_SUM_THREE] ^
      s_q.sign[meter_event_pkg::SG_SUM_THREE];

    clr_ev = '0;
    if (reg_req_i.wr) begin
      if (hit(reg_req_i.addr, meter_event_pkg::ADDR_STATUS)) begin
        clr_ev = reg_req_i.wdata[meter_event_pkg::FLAG_W-1:0];
      end else if (hit(reg_req_i.addr, meter_event_pkg::ADDR_MEAS_MODE)) begin
        s_d.meas_mode = reg_req_i.wdata[meter_event_pkg::MM_W-1:0];
      end else if (hit(reg_req_i.addr, meter_event_pkg::ADDR_PULSE_MODE)) begin
        s_d.pulse_mode = reg_req_i.wdata[meter_event_pkg::PM_W-1:0];
      end
    end
    // A new event in the clearing cycle keeps its flag.
    s_d.status = (s_q.status & ~clr_ev) | set_ev;
    s_d.sign = sign_new;
    s_d.bit30_prev = energy_bit30_i;
    s_d.pulse_prev = pulse_output_i;
    s_d.primed = 1'b1;

    if (reg_req_i.rd) begin
      if (hit(reg_req_i.addr, meter_event_pkg::ADDR_STATUS)) begin
        s_d.rdata = {{(meter_event_pkg::DATA_W-meter_event_pkg::FLAG_W){1'b0}},
                     s_q.status};
      end else if (hit(reg_req_i.addr, meter_event_pkg::ADDR_MEAS_MODE)) begin
        s_d.rdata = {{(meter_event_pkg::DATA_W-meter_event_pkg::MM_W){1'b0}},
                     s_q.meas_mode};
      end else if (hit(reg_req_i.addr, meter_event_pkg::ADDR_PULSE_MODE)) begin
        s_d.rdata = {{(meter_event_pkg::DATA_W-meter_event_pkg::PM_W){1'b0}},
                     s_q.pulse_mode};
      end else if (hit(reg_req_i.addr, meter_event_pkg::ADDR_POWER_SIGN)) begin
        s_d.rdata = {{(meter_event_pkg::DATA_W-meter_event_pkg::SIGN_W){1'b0}},
                     s_q.sign};
      end else begin
        s_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.status <= meter_event_pkg::STATUS_RESET[meter_event_pkg::FLAG_W-1:0];
      s_q.pulse_mode <= meter_event_pkg::PULSE_MODE_RESET;
      s_q.pulse_prev <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign event_status_o = s_q.status;
  assign power_sign_o = s_q.sign;
  assign meas_mode_o = s_q.meas_mode;
  assign pulse_power_select_o =
    s_q.pulse_mode[PHASES*meter_event_pkg::PM_SEL_W-1:0];
  assign pulse_disable_o =
    s_q.pulse_mode[meter_event_pkg::PM_DIS_BASE +: PHASES];

endmodule

// file: tb/flags_checker.sv
// Assertions on the event status flags, bound to the flag block.
`timescale 1ns/1ps
module flags_checker #(
  parameter int PHASES = meter_event_pkg::PHASES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire meter_event_pkg::reg_req_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire meter_event_pkg::energy_bit30_t energy_bit30_i,
  input wire meter_event_pkg::power_sign_in_t power_sign_i,
  input wire logic line_cycle_done_i,
  input wire logic dsp_pass_done_i,
  input wire logic [PHASES-1:0] pulse_output_i,
  input wire logic [18:0] event_status_o,
  input wire logic [8:0] power_sign_o,
  input wire logic [1:0] meas_mode_o
);
  logic st_wr;
  assign st_wr = reg_req_i.wr && reg_req_i.addr == meter_event_pkg::ADDR_STATUS;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  line_flag_a: assert property (line_cycle_done_i |=> event_status_o[5])
    else $error("line cycle flag not set");
  dsp_flag_a: assert property (dsp_pass_done_i |=> event_status_o[17])
    else $error("dsp pass flag not set");
  pulse_fall_a: assert property ($fell(pulse_output_i[0]) |=> event_status_o[14])
    else $error("pulse fall flag not set");
  total_half_a: assert property ($past(rst_n_i) &&
    $changed(energy_bit30_i.total_active) |=> event_status_o[0])
    else $error("energy half flag not set");
  active_sign_a: assert property ((meas_mode_o[0] ?
    power_sign_i.fund_active[0] : power_sign_i.total_active[0])
    != power_sign_o[0] |=> event_status_o[6] && power_sign_o[0] != $past(power_sign_o[0]))
    else $error("active sign flag not set");
  sum_sign_a: assert property (power_sign_i.sum[0] != power_sign_o[3]
    |=> event_status_o[9] && power_sign_o[3] == $past(power_sign_i.sum[0]))
    else $error("sum sign flag or sign wrong");
  read_data_a: assert property (reg_req_i.rd && reg_req_i.addr ==
    meter_event_pkg::ADDR_STATUS |=> reg_rdata_o == {13'h0, $past(event_status_o)})
    else $error("status read data wrong");
  flag_hold_a: assert property (event_status_o[17] &&
    !(st_wr && reg_req_i.wdata[17]) |=> event_status_o[17])
    else $error("flag lost without clear");
  flag_clear_a: assert property (st_wr && reg_req_i.wdata[5] &&
    !line_cycle_done_i |=> !event_status_o[5])
    else $error("flag not cleared");
endmodule
bind metering_event_status_flags flags_checker #(.PHASES(PHASES)) flags_checker_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .energy_bit30_i(energy_bit30_i),
  .power_sign_i(power_sign_i), .line_cycle_done_i(line_cycle_done_i),
  .dsp_pass_done_i(dsp_pass_done_i), .pulse_output_i(pulse_output_i),
  .event_status_o(event_status_o), .power_sign_o(power_sign_o),
  .meas_mode_o(meas_mode_o));

// file: tb/host_port_model.sv
// Host model that reaches the flag registers over the register port.
`timescale 1ns/1ps
module host_port_model (
  input wire logic mclk_i,
  input wire logic [31:0] reg_rdata_i,
  output meter_event_pkg::reg_req_t reg_req_o
);
  initial reg_req_o = '0;
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    #2;
    reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    #2;
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    #2;
    reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge mclk_i);
    #2;
    d = reg_rdata_i;
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hFFFF_FFFF};
  endtask
endmodule

// file: tb/metering_event_status_flags_tb.sv
// Self-checking bench for the metering event status flags.
`timescale 1ns/1ps
module metering_event_status_flags_tb;
  logic mclk_i = 0;
  logic rst_n_i = 0;
  meter_event_pkg::reg_req_t req;
  logic [31:0] rdata, got;
  logic [14:0] e30 = '0, sgn = '0;
  logic line_d = 0, dsp_d = 0;
  logic [2:0] pulse = 3'h7, pdis;
  logic [8:0] sg_o, psel;
  logic [18:0] st;
  logic [1:0] mm;
  int fails = 0, total_checks = 0, cyc = 0;
  int sidx[9] = '{12, 13, 14, 6, 7, 8, 0, 1, 2};
  int sbit[9] = '{6, 7, 8, 10, 11, 12, 9, 13, 18};
  always #12.5 mclk_i = ~mclk_i;
  host_port_model host_port_model_i (.mclk_i(mclk_i),
    .reg_rdata_i(rdata), .reg_req_o(req));
  metering_event_status_flags metering_event_status_flags_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .energy_bit30_i(meter_event_pkg::energy_bit30_t'(e30)),
    .power_sign_i(meter_event_pkg::power_sign_in_t'(sgn)),
    .line_cycle_done_i(line_d), .dsp_pass_done_i(dsp_d),
    .pulse_output_i(pulse), .event_status_o(st), .power_sign_o(sg_o),
    .meas_mode_o(mm), .pulse_power_select_o(psel), .pulse_disable_o(pdis));
  task automatic chk(input logic [31:0] g, x);
    total_checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic status_is(input logic [31:0] x);
    host_port_model_i.rd_reg(meter_event_pkg::ADDR_STATUS, got);
    chk(got, x);
  endtask
  task automatic clear_all();
    host_port_model_i.wr_reg(meter_event_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    #2;
    rst_n_i = 1;
    status_is(32'h0000_0000);
    for (int k = 0; k < 5; k++) begin
      e30[12 - 3 * k + k % 3] = 1'b1;
      status_is(32'h1 << k);
      clear_all();
    end
    line_d = 1;
    @(posedge mclk_i);
    #2;
    line_d = 0;
    status_is(32'h0000_0020);
    clear_all();
    for (int i = 0; i < 9; i++) begin
      sgn[sidx[i]] = 1'b1;
      status_is(32'h1 << sbit[i]);
      clear_all();
    end
    host_port_model_i.rd_reg(meter_event_pkg::ADDR_POWER_SIGN, got);
    chk(got, 32'h0000_01FF);
    chk(sg_o, 32'h0000_01FF);
    // Moving the source to the fundamental powers flips all three signs.
    host_port_model_i.wr_reg(meter_event_pkg::ADDR_MEAS_MODE, 32'h0000_0001);
    status_is(32'h0000_01C0);
    clear_all();
    sgn[9] = 1'b1;
    status_is(32'h0000_0040);
    clear_all();
    host_port_model_i.wr_reg(meter_event_pkg::ADDR_MEAS_MODE, 32'h0000_0003);
    status_is(32'h0000_1C00);
    clear_all();
    chk(sg_o, 32'h0000_0189);
    host_port_model_i.rd_reg(meter_event_pkg::ADDR_MEAS_MODE, got);
    chk(got, 32'h0000_0003);
    chk(mm, 32'h0000_0003);
    host_port_model_i.wr_reg(meter_event_pkg::ADDR_PULSE_MODE, 32'h0000_0E53);
    chk({pdis, psel}, 32'h0000_0E53);
    host_port_model_i.rd_reg(meter_event_pkg::ADDR_PULSE_MODE, got);
    chk(got, 32'h0000_0E53);
    for (int p = 0; p < 3; p++) begin
      pulse[p] = 1'b0;
      status_is(32'h1 << (14 + p));
      pulse[p] = 1'b1;
      clear_all();
    end
    dsp_d = 1;
    @(posedge mclk_i);
    #2;
    dsp_d = 0;
    status_is(32'h0002_0000);
    host_port_model_i.wr_reg(meter_event_pkg::ADDR_STATUS, 32'h0000_0000);
    status_is(32'h0002_0000);
    host_port_model_i.wr_reg(meter_event_pkg::ADDR_STATUS, 32'h0002_0000);
    status_is(32'h0000_0000);
    // A reset in mid-run drops the flags and the mode set before it.
    dsp_d = 1;
    sgn = '0;
    repeat (2) @(posedge mclk_i);
    #2;
    dsp_d = 0;
    rst_n_i = 0;
    repeat (3) @(posedge mclk_i);
    #2;
    rst_n_i = 1;
    status_is(32'h0000_0000);
    host_port_model_i.rd_reg(meter_event_pkg::ADDR_MEAS_MODE, got);
    chk(got, 32'h0000_0000);
    print_verdict();
  end
endmodule
